/* bench/flut4_entry_properties.sv */
// port checker for flut4_entry
// assumes bind onto flut4_entry
`timescale 1ns/10ps
module flut4_entry_properties
(
	// watched ports
	input wire       mclk,
	input wire       rst_b,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire       regWrEn,
	input wire       regRdEn,
	input wire       lutWriteEnable,
	input wire       tempHiRes,
	input wire       dutyHiRes,
	input wire       pwmFreq22k,
	input wire [7:0] remoteTempDeg,
	input wire [7:0] regRdData_q,
	input wire       entryActive_q,
	input wire [7:0] pwmDuty_q,
	input wire       dutyWide_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wide_flag_a: assert property ($past(rst_b) |-> dutyWide_q==$past(dutyHiRes&pwmFreq22k)) else $error("wide");
	idle_duty_a: assert property (!entryActive_q |-> pwmDuty_q==8'h00) else $error("idle duty");
	narrow_duty_a: assert property (entryActive_q && !dutyWide_q |-> pwmDuty_q[7:6]==2'b00) else $error("narrow");
	limit_low_a: assert property (!tempHiRes ##1 !tempHiRes && regRdEn && regAddr==8'h56 |=> !regRdData_q[7])
		else $error("lim");
	duty_low_a: assert property (!dutyHiRes ##1 !dutyHiRes && regRdEn && regAddr==8'h57 |=> regRdData_q[7:6]==2'b00)
		else $error("dut");
	// back-to-back write then read of the duty byte
	write_back_a: assert property (
		regWrEn && lutWriteEnable && regAddr==8'h57 && dutyHiRes ##1 regRdEn && regAddr==8'h57 && dutyHiRes
		|=> regRdData_q==$past(regWrData, 2)) else $error("wb");
	hot_active_a: assert property (remoteTempDeg[7] |=> entryActive_q) else $error("hot");
	cold_idle_a: assert property (!tempHiRes && remoteTempDeg==8'h00 |=> !entryActive_q) else $error("cold");
endmodule
bind flut4_entry flut4_entry_properties i_chk
(
	.mclk           (mclk),
	.rst_b          (rst_b),
	.regAddr        (regAddr),
	.regWrData      (regWrData),
	.regWrEn        (regWrEn),
	.regRdEn        (regRdEn),
	.lutWriteEnable (lutWriteEnable),
	.tempHiRes      (tempHiRes),
	.dutyHiRes      (dutyHiRes),
	.pwmFreq22k     (pwmFreq22k),
	.remoteTempDeg  (remoteTempDeg),
	.regRdData_q    (regRdData_q),
	.entryActive_q  (entryActive_q),
	.pwmDuty_q      (pwmDuty_q),
	.dutyWide_q     (dutyWide_q)
);

/* bench/flut4_entry_test.sv */
// bench for flut4_entry registers and fan output
// assumes the checker file is compiled too
`timescale 1ns/10ps
module flut4_entry_test;
	logic       mclk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, rdSeen = 0, act, entryActive_q, dutyWide_q;
	logic       lutWriteEnable = 0, tempHiRes = 0, dutyHiRes = 0, pwmFreq22k = 0, remoteTempHalf = 0;
	logic [7:0] regAddr = 0, regWrData = 0, remoteTempDeg = 0, regRdData_q, pwmDuty_q, lim, dut, notes[$];
	int         err_count = 0, n_tests = 0, cyc = 0;
	flut4_entry i_dut (.*);
	always #5 mclk = ~mclk;
	task chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			$display("mismatch %0t %h %h", $time, s, e);
			err_count++;
		end
	endtask
	// strobes are lowered by the next call or by the caller, never twice in one step
	task wr(input logic [7:0] a, d);
		regRdEn <= 0;
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, e);
		notes.push_back(e);
		regWrEn <= 0;
		regAddr <= a;
		regRdEn <= 1;
		@(posedge mclk);
	endtask
	task report_and_stop;
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		if (rdSeen)
			chk(regRdData_q, notes.pop_front());
		rdSeen <= regRdEn;
		if (++cyc > 999)
		begin
			err_count++;
			report_and_stop;
		end
	end
	initial
	begin
		void'($urandom(32'h0000_7264));
		repeat (6) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		rd(8'h56, 8'h7F);
		rd(8'h57, 8'h3F);
		rd(8'h10, 8'h00);
		// write refused while the table is locked
		wr(8'h57, 8'h00);
		rd(8'h57, 8'h3F);
		regRdEn <= 0;
		$display("reset test done");
		lutWriteEnable <= 1;
		repeat (40)
		begin
			{tempHiRes, dutyHiRes, pwmFreq22k} <= 3'($urandom);
			{remoteTempDeg, remoteTempHalf} <= 9'($urandom % 320);
			lim = 8'($urandom);
			dut = 8'($urandom);
			@(posedge mclk);
			wr(8'h56, lim);
			rd(8'h56, tempHiRes ? lim : lim & 8'h7F);
			wr(8'h57, dut);
			rd(8'h57, dutyHiRes ? dut : dut & 8'h3F);
			regRdEn <= 0;
			@(posedge mclk);
			// look at the settled outputs, away from the launching edge
			@(negedge mclk);
			act = tempHiRes ? {lim[6:0], lim[7]} < {remoteTempDeg, remoteTempHalf} : lim[6:0] < remoteTempDeg;
			dut = dutyHiRes & pwmFreq22k ? dut : dut & 8'h3F;
			chk({7'h00, entryActive_q}, {7'h00, act});
			chk(pwmDuty_q, act ? dut : 8'h00);
			@(posedge mclk);
			rd(8'hF4, {5'h00, 1'b1, dutyHiRes & pwmFreq22k, act});
			regRdEn <= 0;
		end
		repeat (2) @(posedge mclk);
		$display("random test done");
		report_and_stop;
	end
endmodule

/* rtl/flut4_entry.v */
// fourth breakpoint of the fan lookup table: limit and duty registers,
// the temperature compare and the duty value handed to the pwm output.
// assumes mode bits, write enable and temperature come from logic on mclk.
`timescale 1ns/10ps
`include "flut4_regs.vh"

// Notes on behaviour
// (R1) writes accepted only while lut write enabled
// (R2) low-res temperature mode: limit top bit zero
// (R3) high-res limit half degrees, low-res whole
// (R4) temperature above limit drives paired duty
// (R5) compare nine bits high-res, eight low-res
// (R6) limit sign bit always taken as zero
// (R7) software uses offset register for higher limits
// (R8) low-res duty mode: upper two bits zero
// (R9) high-res duty: eight-bit value from both fields
// (R10) extended duty bits only at 22.5 kHz
// (R11) low-res pwm uses lower six duty bits
// (R12) reset loads limit 0x7F, duty 0x3F
module flut4_entry
(
	// clock and reset
	input  wire       mclk,
	input  wire       rst_b,
	// register port
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrEn,
	input  wire       regRdEn,
	output reg  [7:0] regRdData_q,
	// configuration from the rest of the device
	input  wire       lutWriteEnable,
	input  wire       tempHiRes,
	input  wire       dutyHiRes,
	input  wire       pwmFreq22k,
	// remote diode reading, unsigned whole degrees plus half bit
	input  wire [7:0] remoteTempDeg,
	input  wire       remoteTempHalf,
	// toward the pwm generator
	output reg        entryActive_q,
	output reg  [7:0] pwmDuty_q,
	output reg        dutyWide_q
);

	reg  [7:0] limit_q;
	reg  [7:0] limit_d;
	reg  [7:0] duty_q;
	reg  [7:0] duty_d;
	reg  [7:0] rdData_d;
	reg  [8:0] limitCmp;
	reg  [8:0] tempCmp;
	reg  [7:0] dutySel;
	wire       wideOk;
	wire       hit;
	wire       wrAllowed;
	wire       limitWrSel;
	wire       dutyWrSel;

	// extended bits need both the wide duty mode and the fast pwm rate
	// (R10) gate on frequency
	assign wideOk = dutyHiRes & pwmFreq22k;

	// write decode; a locked table drops the write with no error flag
	// (R1) write enable gate
	assign wrAllowed  = regWrEn & lutWriteEnable;
	assign limitWrSel = wrAllowed & (regAddr == `FLUT4_LIMIT_OFF);
	assign dutyWrSel  = wrAllowed & (regAddr == `FLUT4_DUTY_OFF);

	// limit next value; the mode clear wins over a write in the same cycle
	always @*
	begin
		limit_d = limit_q;
		if (limitWrSel)
			limit_d = regWrData;
		// (R2) clear half bit
		if (!tempHiRes)
			limit_d[`FLUT4_HALF_BIT] = 1'b0;
	end

	// duty next value; the mode clear wins over a write in the same cycle
	always @*
	begin
		duty_d = duty_q;
		if (dutyWrSel)
			duty_d = regWrData;
		// (R8) clear extended bits
		if (!dutyHiRes)
			duty_d[`FLUT4_EXT_MSB:`FLUT4_EXT_LSB] = 2'b00;
	end

	// (R12) power-on values
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			limit_q <= `FLUT4_LIMIT_RST;
			duty_q  <= `FLUT4_DUTY_RST;
		end
		else
		begin
			limit_q <= limit_d;
			duty_q  <= duty_d;
		end
	end

	// compare operands in half-degree units
	always @*
	begin
		// (R3) (R6) unsigned limit, half bit as lsb
		if (tempHiRes)
			limitCmp = {1'b0, limit_q[`FLUT4_DEG_MSB:0], limit_q[`FLUT4_HALF_BIT]};
		else
			limitCmp = {1'b0, limit_q[`FLUT4_DEG_MSB:0], 1'b0};
		// (R5) nine or eight temperature bits
		if (tempHiRes)
			tempCmp = {remoteTempDeg, remoteTempHalf};
		else
			tempCmp = {remoteTempDeg, 1'b0};
	end

	// strictly greater; equal temperature leaves the entry idle
	// (R4) exceed test
	assign hit = (tempCmp > limitCmp);

	// duty value offered for this entry
	always @*
	begin
		// (R9) full eight bits
		if (wideOk)
			dutySel = duty_q;
		// (R11) six-bit duty
		else
			dutySel = {2'b00, duty_q[`FLUT4_BASE_MSB:0]};
	end

	// (R4) drive paired duty
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			entryActive_q <= 1'b0;
			pwmDuty_q     <= 8'h00;
			dutyWide_q    <= 1'b0;
		end
		else
		begin
			entryActive_q <= hit;
			pwmDuty_q     <= hit ? dutySel : 8'h00;
			dutyWide_q    <= wideOk;
		end
	end

	// read mux, answer one cycle after the strobe
	always @*
	begin
		rdData_d = `FLUT4_RD_ZERO;
		case (regAddr)
			`FLUT4_LIMIT_OFF:
				rdData_d = limit_q;
			`FLUT4_DUTY_OFF:
				rdData_d = duty_q;
			`FLUT4_STAT_OFF:
			begin
				rdData_d[`FLUT4_STAT_ACTIVE] = entryActive_q;
				rdData_d[`FLUT4_STAT_WIDE]   = dutyWide_q;
				rdData_d[`FLUT4_STAT_WREN]   = lutWriteEnable;
			end
			default:
				rdData_d = `FLUT4_RD_ZERO;
		endcase
	end

	// data held only in the cycle after a read, zero otherwise
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			regRdData_q <= 8'h00;
		else if (regRdEn)
			regRdData_q <= rdData_d;
		else
			regRdData_q <= 8'h00;
	end

endmodule

/* rtl/flut4_regs.vh */
// constants of the fourth lookup-table entry: offsets, fields, reset values
// assumes inclusion by bare name from the design files under rtl/
`ifndef FLUT4_REGS_VH
`define FLUT4_REGS_VH

// register offsets (byte-wide register port)
`define FLUT4_LIMIT_OFF      8'h56
`define FLUT4_DUTY_OFF       8'h57
`define FLUT4_STAT_OFF       8'hF4

// limit register fields
`define FLUT4_HALF_BIT       7
`define FLUT4_DEG_MSB        6

// duty register fields
`define FLUT4_EXT_MSB        7
`define FLUT4_EXT_LSB        6
`define FLUT4_BASE_MSB       5

// status register fields
`define FLUT4_STAT_ACTIVE    0
`define FLUT4_STAT_WIDE      1
`define FLUT4_STAT_WREN      2

// power-on values and the read-mux default
`define FLUT4_LIMIT_RST      8'h7F
`define FLUT4_DUTY_RST       8'h3F
`define FLUT4_RD_ZERO        8'h00

`endif
